// ===== logic/wtr_cfg.svh
`ifndef WTR_CFG_SVH
`define WTR_CFG_SVH

// Register byte addresses
`define WTR_ADDR_CTRL     12'h000
`define WTR_ADDR_RSTFLAG  12'h004
`define WTR_ADDR_STATUS   12'h008
`define WTR_ADDR_MASK     12'h00c
`define WTR_ADDR_COUNT    12'h010

// Control register fields
`define WTR_CTRL_FLAG     7
`define WTR_CTRL_IE       6
`define WTR_CTRL_TS3      5
`define WTR_CTRL_UNLOCK   4
`define WTR_CTRL_SRE      3
`define WTR_CTRL_TS_HI    2
`define WTR_CTRL_TS_LO    0

// Reset flag register field
`define WTR_RSTFLAG_BIT   3

// Event status and mask fields
`define WTR_EV_TIMEOUT    0
`define WTR_EV_SYSRESET   1
`define WTR_EV_W          2

// Timing
`define WTR_UNLOCK_CYCLES 3'd4
`define WTR_TSEL_MAX      4'h9
`define WTR_BASE_CYCLES   2048
`define WTR_OSC_HZ        128000
`define WTR_TOUT_MIN_MS   16
`define WTR_TOUT_MAX_MS   8000
`define WTR_STARTUP_CYCLES 1024

`endif

// ===== logic/wtr_pkg.sv
`default_nettype none
package wtr_pkg;

   typedef enum logic [1:0]
   {
      WTR_MODE_STOPPED   = 2'b00,
      WTR_MODE_IRQ       = 2'b01,
      WTR_MODE_RESET     = 2'b10,
      WTR_MODE_IRQ_RESET = 2'b11
   } wtr_mode_type;

endpackage : wtr_pkg
`default_nettype wire

// ===== logic/wtr_sync.sv
`timescale 1ns/1ps
`default_nettype none
module wtr_sync
   import wtr_pkg::*;
#(
   parameter int WIDTH = 1
)
(
   input  wire logic             pclk,
   input  wire logic             presetn,
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);

   logic [WIDTH-1:0] stage1;
   logic [WIDTH-1:0] stage2;
   logic [WIDTH-1:0] stage3;
   logic [WIDTH-1:0] next_out;

   // Output moves only once the two later stages agree
   genvar i;
   generate
      for (i = 0; i < WIDTH; i++)
      begin : g_bit
         always_comb
         begin
            next_out[i] = (stage2[i] == stage3[i]) ? stage3[i] : sync_out[i];
         end
      end
   endgenerate

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         stage1   <= '0;
         stage2   <= '0;
         stage3   <= '0;
         sync_out <= '0;
      end
      else
      begin
         stage1   <= async_in;
         stage2   <= stage1;
         stage3   <= stage2;
         sync_out <= next_out;
      end
   end

endmodule : wtr_sync
`default_nettype wire

// ===== logic/wtr_supervisor.sv
`timescale 1ns/1ps
`default_nettype none
`include "wtr_cfg.svh"

module wtr_supervisor
   import wtr_pkg::*;
#(
   parameter int BASE_CYCLES    = `WTR_BASE_CYCLES,
   parameter int STARTUP_CYCLES = `WTR_STARTUP_CYCLES
)
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        osc_clk_in,
   input  wire logic        always_on_fuse,
   input  wire logic        restart_req,
   input  wire logic        vector_ack,
   output logic             timeout_irq,
   output logic             irq,
   output logic             system_reset,
   output logic             startup_hold
);

   localparam int CW = 21;
   localparam int SW = 24;

   logic          osc_sync;
   logic          fuse_sync;
   logic          osc_prev;
   logic          osc_tick;
   logic          access;
   logic          wr;
   logic          wr_ctrl;
   logic          unlock_open;
   logic [3:0]    wr_tsel;
   logic [CW-1:0] limit;
   logic          running;
   logic          timeout;
   logic          reset_due;
   logic          falling;
   wtr_mode_type  mode;

   logic          sre;
   logic          ie;
   logic          flag;
   logic [3:0]    tsel;
   logic [2:0]    unlock_cnt;
   logic          rst_flag;
   logic [`WTR_EV_W-1:0] status;
   logic [`WTR_EV_W-1:0] mask;
   logic [CW-1:0] count;
   logic          pulse_d;
   logic [SW-1:0] startup_cnt;

   logic          next_sre;
   logic          next_ie;
   logic          next_flag;
   logic [3:0]    next_tsel;
   logic [2:0]    next_unlock_cnt;
   logic          next_rst_flag;
   logic [`WTR_EV_W-1:0] next_status;
   logic [`WTR_EV_W-1:0] next_mask;
   logic [CW-1:0] next_count;
   logic          next_system_reset;
   logic [SW-1:0] next_startup_cnt;
   logic          next_startup_hold;
   logic          next_timeout_irq;
   logic          next_irq;
   logic          next_pready;
   logic          next_pslverr;
   logic [31:0]   next_prdata;

   wtr_sync #(.WIDTH(2)) u_sync
   (
      .pclk     (pclk),
      .presetn  (presetn),
      .async_in ({always_on_fuse, osc_clk_in}),
      .sync_out ({fuse_sync, osc_sync})
   );

   assign osc_tick    = osc_sync & ~osc_prev;
   assign access      = psel & penable & pready;
   assign wr          = access & pwrite;
   assign wr_ctrl     = wr & (paddr == `WTR_ADDR_CTRL);
   assign unlock_open = (unlock_cnt != 3'd0);
   assign wr_tsel     = {pwdata[`WTR_CTRL_TS3], pwdata[`WTR_CTRL_TS_HI:`WTR_CTRL_TS_LO]};
   assign mode        = wtr_mode_type'({sre, ie});

   assign limit   = CW'(BASE_CYCLES) << tsel;
   assign running = (mode != WTR_MODE_STOPPED);

   // 16 ms to 8 s span
   assign timeout = running & osc_tick & (count >= limit - CW'(1));

   assign reset_due = timeout & sre & (~ie | flag);

   always_comb
   begin
      next_count = count;
      if (restart_req || !running)
         next_count = '0;
      else if (timeout)
         next_count = '0;
      else if (osc_tick)
         next_count = count + CW'(1);
   end

   always_comb
   begin
      next_sre        = sre;
      next_ie         = ie;
      next_tsel       = tsel;
      next_flag       = flag;
      next_unlock_cnt = unlock_open ? unlock_cnt - 3'd1 : 3'd0;

      if (vector_ack && mode == WTR_MODE_IRQ_RESET)
         next_ie = 1'b0;

      if (wr_ctrl)
      begin
         next_ie = pwdata[`WTR_CTRL_IE];
         if (pwdata[`WTR_CTRL_UNLOCK] && pwdata[`WTR_CTRL_SRE])
         begin
            next_sre        = 1'b1;
            next_unlock_cnt = `WTR_UNLOCK_CYCLES;
         end
         else if (unlock_open && !pwdata[`WTR_CTRL_UNLOCK])
         begin
            next_sre        = pwdata[`WTR_CTRL_SRE];
            next_unlock_cnt = 3'd0;
            // Reserved codes keep the old length
            if (wr_tsel <= `WTR_TSEL_MAX)
               next_tsel = wr_tsel;
         end
         else if (pwdata[`WTR_CTRL_SRE])
            next_sre = 1'b1;
      end

      // flag clear by write or vector
      if ((wr_ctrl && pwdata[`WTR_CTRL_FLAG]) || vector_ack)
         next_flag = 1'b0;
      if (timeout && ie && !reset_due)
         next_flag = 1'b1;

      if (rst_flag || next_rst_flag)
         next_sre = 1'b1;
      if (fuse_sync)
      begin
         next_sre = 1'b1;
         next_ie  = 1'b0;
      end
   end

   always_comb
   begin
      next_rst_flag = rst_flag;
      next_status   = status;
      next_mask     = mask;
      if (wr && paddr == `WTR_ADDR_RSTFLAG && !pwdata[`WTR_RSTFLAG_BIT])
         next_rst_flag = 1'b0;
      if (wr && paddr == `WTR_ADDR_STATUS)
         next_status = status & ~pwdata[`WTR_EV_W-1:0];
      if (wr && paddr == `WTR_ADDR_MASK)
         next_mask = pwdata[`WTR_EV_W-1:0];
      // Set wins over clear
      if (system_reset)
         next_rst_flag = 1'b1;
      if (timeout)
         next_status[`WTR_EV_TIMEOUT] = 1'b1;
      if (system_reset)
         next_status[`WTR_EV_SYSRESET] = 1'b1;
   end

   always_comb
   begin
      next_system_reset = reset_due;
      falling           = pulse_d & ~system_reset;
      next_startup_cnt  = (startup_cnt != '0) ? startup_cnt - SW'(1) : '0;
      if (falling)
         next_startup_cnt = SW'(STARTUP_CYCLES);
      next_startup_hold = system_reset | (next_startup_cnt != '0);
      next_timeout_irq  = next_flag & next_ie;
      next_irq          = |(next_status & next_mask);
   end

   // One wait state keeps every answer registered
   always_comb
   begin
      next_pready  = psel & penable & ~pready;
      next_pslverr = 1'b0;
      next_prdata  = prdata;
      if (psel && penable && !pready)
      begin
         next_prdata = '0;
         unique case (paddr)
            `WTR_ADDR_CTRL:
            begin
               next_prdata[`WTR_CTRL_FLAG]                   = flag;
               next_prdata[`WTR_CTRL_IE]                     = ie;
               next_prdata[`WTR_CTRL_TS3]                    = tsel[3];
               next_prdata[`WTR_CTRL_UNLOCK]                 = unlock_open;
               next_prdata[`WTR_CTRL_SRE]                    = sre;
               next_prdata[`WTR_CTRL_TS_HI:`WTR_CTRL_TS_LO]  = tsel[2:0];
            end
            `WTR_ADDR_RSTFLAG: next_prdata[`WTR_RSTFLAG_BIT] = rst_flag;
            `WTR_ADDR_STATUS:  next_prdata[`WTR_EV_W-1:0]    = status;
            `WTR_ADDR_MASK:    next_prdata[`WTR_EV_W-1:0]    = mask;
            `WTR_ADDR_COUNT:   next_prdata[CW-1:0]           = count;
            default:           next_pslverr                  = 1'b1;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         osc_prev     <= 1'b0;
         sre          <= 1'b0;
         ie           <= 1'b0;
         flag         <= 1'b0;
         tsel         <= 4'h0;
         unlock_cnt   <= 3'd0;
         rst_flag     <= 1'b0;
         status       <= '0;
         mask         <= '0;
         count        <= '0;
         pulse_d      <= 1'b0;
         system_reset <= 1'b0;
         startup_cnt  <= '0;
         startup_hold <= 1'b0;
         timeout_irq  <= 1'b0;
         irq          <= 1'b0;
         pready       <= 1'b0;
         pslverr      <= 1'b0;
         prdata       <= 32'h0000_0000;
      end
      else
      begin
         osc_prev     <= osc_sync;
         sre          <= next_sre;
         ie           <= next_ie;
         flag         <= next_flag;
         tsel         <= next_tsel;
         unlock_cnt   <= next_unlock_cnt;
         rst_flag     <= next_rst_flag;
         status       <= next_status;
         mask         <= next_mask;
         count        <= next_count;
         pulse_d      <= system_reset;
         system_reset <= next_system_reset;
         startup_cnt  <= next_startup_cnt;
         startup_hold <= next_startup_hold;
         timeout_irq  <= next_timeout_irq;
         irq          <= next_irq;
         pready       <= next_pready;
         pslverr      <= next_pslverr;
         prdata       <= next_prdata;
      end
   end

endmodule : wtr_supervisor
`default_nettype wire

// ===== tb/wtr_supervisor_properties.sv
`timescale 1ns/1ps
`default_nettype none
module wtr_supervisor_properties
#(
   parameter int BASE_CYCLES    = 4,
   parameter int STARTUP_CYCLES = 8
)
(
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        osc_clk_in,
   input wire logic        always_on_fuse,
   input wire logic        restart_req,
   input wire logic        vector_ack,
   input wire logic        timeout_irq,
   input wire logic        irq,
   input wire logic        system_reset,
   input wire logic        startup_hold
);
   default clocking @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   sequence s_access;
      psel && $rose(penable);
   endsequence
   sequence s_pulse_end;
      $fell(system_reset) && startup_hold;
   endsequence
   property p_wait; s_access |=> pready; endproperty
   a_wait: assert property (p_wait) else $error("No answer after one wait state");
   property p_err; pslverr |-> pready; endproperty
   a_err: assert property (p_err) else $error("Error flag without ready");
   property p_pulse; system_reset |=> !system_reset; endproperty
   a_pulse: assert property (p_pulse) else $error("Reset pulse too long");
   // Hold follows the pulse by one clock, then lasts through the whole start-up count
   property p_hold; system_reset |=> s_pulse_end ##1 startup_hold [*8] ##1 !startup_hold; endproperty
   a_hold: assert property (p_hold) else $error("Start-up hold cut short");
   property p_tick; system_reset |-> $past(osc_clk_in, 4); endproperty
   a_tick: assert property (p_tick) else $error("Reset without oscillator tick");
   // Cleared counter cannot expire within a few clocks
   property p_restart; restart_req |=> !system_reset [*4]; endproperty
   a_restart: assert property (p_restart) else $error("Reset right after restart");
   property p_fuse; always_on_fuse [*8] |-> !timeout_irq; endproperty
   a_fuse: assert property (p_fuse) else $error("Interrupt with fuse set");
   property p_vec; vector_ack |-> ##2 !timeout_irq; endproperty
   a_vec: assert property (p_vec) else $error("Vector left interrupt high");
endmodule : wtr_supervisor_properties
bind wtr_supervisor wtr_supervisor_properties
#(
   .BASE_CYCLES    (BASE_CYCLES),
   .STARTUP_CYCLES (STARTUP_CYCLES)
)
u_chk
(
   .pclk           (pclk),
   .presetn        (presetn),
   .psel           (psel),
   .penable        (penable),
   .pwrite         (pwrite),
   .paddr          (paddr),
   .pwdata         (pwdata),
   .prdata         (prdata),
   .pready         (pready),
   .pslverr        (pslverr),
   .osc_clk_in     (osc_clk_in),
   .always_on_fuse (always_on_fuse),
   .restart_req    (restart_req),
   .vector_ack     (vector_ack),
   .timeout_irq    (timeout_irq),
   .irq            (irq),
   .system_reset   (system_reset),
   .startup_hold   (startup_hold)
);
`default_nettype wire

// ===== tb/wtr_supervisor_test.sv
`timescale 1ns/1ps
`default_nettype none
`include "wtr_cfg.svh"
module wtr_supervisor_test
   import wtr_pkg::*;
;
   localparam logic [11:0] CTL = `WTR_ADDR_CTRL;
   localparam logic [11:0] RFL = `WTR_ADDR_RSTFLAG;
   localparam logic [11:0] STA = `WTR_ADDR_STATUS;
   localparam logic [11:0] MSK = `WTR_ADDR_MASK;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
   logic        osc_clk_in, always_on_fuse, restart_req, vector_ack;
   logic        timeout_irq, irq, system_reset, startup_hold;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [3:0]  ts;
   int          bad_count, cmp_count, rst_seen, t, n;

   // Short base count keeps the run small
   wtr_supervisor #(.BASE_CYCLES(4), .STARTUP_CYCLES(8)) dut
   (
      .pclk           (pclk),
      .presetn        (presetn),
      .psel           (psel),
      .penable        (penable),
      .pwrite         (pwrite),
      .paddr          (paddr),
      .pwdata         (pwdata),
      .prdata         (prdata),
      .pready         (pready),
      .pslverr        (pslverr),
      .osc_clk_in     (osc_clk_in),
      .always_on_fuse (always_on_fuse),
      .restart_req    (restart_req),
      .vector_ack     (vector_ack),
      .timeout_irq    (timeout_irq),
      .irq            (irq),
      .system_reset   (system_reset),
      .startup_hold   (startup_hold)
   );

   initial
   begin
      pclk = 0;
      forever #25 pclk = ~pclk;
   end
   initial
   begin
      osc_clk_in = 0;
      forever #3906 osc_clk_in = ~osc_clk_in;
   end
   always @(posedge pclk)
      if (system_reset === 1'b1)
         rst_seen <= rst_seen + 1;

   task automatic conclude;
      $display("Compares %0d, mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : conclude

   task automatic chk(input logic [31:0] g, e);
      cmp_count++;
      if (g !== e)
      begin
         bad_count++;
         $display("BAD %0t got %h exp %h", $time, g, e);
      end
   endtask : chk

   // Idle edge first, so psel never toggles twice in one step
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int k;
      @(posedge pclk);
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      k = 0;
      do
      begin
         @(posedge pclk);
         k++;
      end
      while (pready !== 1'b1 && k < 20);
      chk(pready, 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 0;
      penable <= 0;
   endtask : apb

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask : wr

   task automatic rc(input logic [11:0] a, input logic [31:0] m, e);
      apb(1'b0, a, 32'h0);
      chk(rd & m, e);
   endtask : rc

   task automatic kick;
      @(posedge pclk);
      restart_req <= 1;
      @(posedge pclk);
      restart_req <= 0;
   endtask : kick

   task automatic wait_out(input int which, input int lim);
      t = 0;
      while ((which == 0 ? timeout_irq : system_reset) !== 1'b1 && t < lim)
      begin
         @(posedge pclk);
         t++;
      end
      chk(t < lim, 1'b1);
   endtask : wait_out

   // Oscillator phase is free, so allow one tick of slack
   function automatic logic in_range(input int c, input int s);
      int l;
      l = 4 << s;
      return c > (l - 1) * 156 && c <= l * 157 + 10;
   endfunction : in_range

   initial
   begin
      #3000000;
      bad_count++;
      conclude();
   end

   initial
   begin
      bad_count = 0;
      cmp_count = 0;
      rst_seen = 0;
      {psel, penable, pwrite, restart_req, vector_ack, always_on_fuse} = '0;
      paddr = '0;
      pwdata = '0;
      presetn = 0;
      void'($urandom(32'h285702d4));
      repeat (2) @(posedge pclk);
      presetn <= 1;
      rc(CTL, 32'hff, 32'h0);
      rc(12'h020, 32'hffffffff, 32'h0);
      chk(err, 1'b1);
      wr(MSK, 32'h3);
      for (n = 0; n < 3; n++)
      begin
         ts = 4'($urandom_range(2, 0));
         wr(CTL, 32'h18);
         wr(CTL, 32'h40 | ts);
         rc(CTL, 32'h7f, 32'h40 | ts);
         kick();
         wait_out(0, 3000);
         chk(in_range(t, ts), 1'b1);
         chk(irq, 1'b1);
         @(posedge pclk) vector_ack <= 1;
         @(posedge pclk) vector_ack <= 0;
         repeat (3) @(posedge pclk);
         chk(timeout_irq, 1'b0);
         wr(STA, 32'h1);
         rc(STA, 32'h1, 32'h0);
         chk(irq, 1'b0);
      end
      chk(rst_seen, 0);
      wr(MSK, 32'h0);
      kick();
      wait_out(0, 3000);
      rc(STA, 32'h1, 32'h1);
      chk(irq, 1'b0);
      wr(STA, 32'h1);
      wr(CTL, 32'h80 | ts);
      rc(CTL, 32'hc0, 32'h0);
      wr(CTL, 32'h43);
      rc(CTL, 32'h7f, 32'h40 | ts);
      wr(CTL, 32'h18 | ts);
      repeat (6) @(posedge pclk);
      wr(CTL, 32'h40);
      rc(CTL, 32'h7f, 32'h48 | ts);
      wr(CTL, 32'h18 | ts);
      wr(CTL, 32'h6a);
      rc(CTL, 32'h27, 32'(ts));
      wr(CTL, 32'h18);
      wr(CTL, 32'h48);
      kick();
      wait_out(0, 1000);
      chk(rst_seen, 0);
      wait_out(1, 1000);
      chk(in_range(t, 0), 1'b1);
      // Hold spans pulse edge plus eight start-up clocks
      repeat (9) @(posedge pclk);
      chk(startup_hold, 1'b1);
      @(posedge pclk);
      chk(startup_hold, 1'b0);
      rc(RFL, 32'h8, 32'h8);
      rc(CTL, 32'h8, 32'h8);
      wr(CTL, 32'h18);
      wr(CTL, 32'h80);
      rc(CTL, 32'hc8, 32'h8);
      wr(RFL, 32'h0);
      rc(RFL, 32'h8, 32'h0);
      wr(CTL, 32'h18);
      wr(CTL, 32'h0);
      rc(CTL, 32'hff, 32'h0);
      wr(CTL, 32'h8);
      for (n = 0; n < 12; n++)
      begin
         kick();
         repeat ($urandom_range(400, 50)) @(posedge pclk);
      end
      chk(rst_seen, 1);
      wait_out(1, 1000);
      wr(RFL, 32'h0);
      wr(CTL, 32'h18);
      wr(CTL, 32'h0);
      always_on_fuse <= 1;
      repeat (8) @(posedge pclk);
      wr(CTL, 32'h40);
      rc(CTL, 32'h48, 32'h8);
      kick();
      wait_out(1, 1000);
      conclude();
   end
endmodule : wtr_supervisor_test
`default_nettype wire
